// >>> mxp_pkg.sv
// package: constants and types of the memory paging block
package mxp_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] MXP_OFF_SEL_DATA  = 8'h00;
    localparam logic [7:0] MXP_OFF_EXP_DATA  = 8'h04;
    localparam logic [7:0] MXP_OFF_SEL_DIR   = 8'h08;
    localparam logic [7:0] MXP_OFF_EXP_DIR   = 8'h0C;
    localparam logic [7:0] MXP_OFF_PROG_PAGE = 8'h10;
    localparam logic [7:0] MXP_OFF_XTRA_PAGE = 8'h14;
    localparam logic [7:0] MXP_OFF_WIN_EN    = 8'h18;
    localparam logic [7:0] MXP_OFF_PIN_ASGN  = 8'h1C;
    localparam logic [7:0] MXP_OFF_SEL_EN    = 8'h20;
    localparam logic [7:0] MXP_OFF_STRETCH   = 8'h24;
    localparam logic [7:0] MXP_OFF_MISC      = 8'h28;
    localparam logic [7:0] MXP_OFF_DATA_PAGE = 8'h34;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int MXP_WIN_DATA_BIT  = 7;
    localparam int MXP_WIN_PROG_BIT  = 6;
    localparam int MXP_WIN_XTRA_BIT  = 5;
    localparam int MXP_MISC_LOC_BIT  = 0;
    localparam int MXP_MISC_STR_BIT  = 1;
    localparam int MXP_MISC_VIS_BIT  = 2;
    localparam int MXP_MISC_NCK_BIT  = 3;
    localparam int MXP_MISC_PUP_BIT  = 4;
    localparam int MXP_MISC_SGL_BIT  = 5;
    localparam int MXP_MISC_FLW_BIT  = 6;
    localparam int MXP_CS_THREE      = 6;

    // ------------------------------------------------------------
    // reset values and sizes
    // ------------------------------------------------------------
    localparam logic [7:0]  MXP_RST_BYTE    = 8'h00;
    localparam logic [13:0] MXP_RST_STRETCH = 14'h0000;
    localparam int          MXP_NUM_CS      = 7;
    localparam int          MXP_NUM_EXT     = 6;
    localparam int          MXP_E_DIV       = 4;

    // cpu access on the internal address side
    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
    } mxp_access_t;

    // paged call / return load of the program page
    typedef struct packed {
        logic       load;
        logic [7:0] page;
    } mxp_page_load_t;

endpackage

// >>> mxp_paging.sv
// memory expansion paging, port override and chip-select stretch logic
//
// What this block does
// - data window maps data page onto addr 19..12
// - data window drives bits 20,21 high
// - program window maps program page onto 21..14
// - extra window maps page onto 17..10, 21..18 high
// - each page register picks one of 256 pages
// - window enable bits gate their page register
// - assign bit makes pin address output, else gpio
// - single-chip mode ignores pin assignment bits
// - outside single-chip mode, enabled chip-select overrides port direction and data
// - unclaimed pins are gpio, pulled up as inputs
// - direction bit one means output, zero input
// - each chip-select stretches zero to three cycles
// - clock pin shows stretched, plain or no clock
// - paged call and return load program page
// - all registers readable and writable any time
// - address bits 9..0 always pass unchanged
// - bits 21..16 high outside windows, upper passes through
// - location bit picks first or second kilobyte
`timescale 1ns/1ps

module mxp_paging
    import mxp_pkg::*;
#(
    parameter int E_DIV = MXP_E_DIV
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire mxp_access_t            cpu_access,
    input  wire logic [MXP_NUM_CS-1:0]  cs_hit,
    input  wire mxp_page_load_t         page_call,
    input  wire mxp_page_load_t         page_return,
    output logic [21:0]                 ext_addr,
    output logic                        bus_stretch,
    output logic                        eclk_pin,
    input  wire logic [MXP_NUM_CS-1:0]  select_port_in,
    output logic [MXP_NUM_CS-1:0]       select_port_out,
    output logic [MXP_NUM_CS-1:0]       select_port_oe,
    output logic [MXP_NUM_CS-1:0]       select_port_pullup,
    input  wire logic [MXP_NUM_EXT-1:0] expansion_port_in,
    output logic [MXP_NUM_EXT-1:0]      expansion_port_out,
    output logic [MXP_NUM_EXT-1:0]      expansion_port_oe,
    output logic [MXP_NUM_EXT-1:0]      expansion_port_pullup
);

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [7:0]            select_port_data_q;
    logic [7:0]            expansion_port_data_q;
    logic [7:0]            select_port_direction_q;
    logic [7:0]            expansion_port_direction_q;
    logic [7:0]            data_page_select_q;
    logic [7:0]            program_page_select_q;
    logic [7:0]            extra_page_select_q;
    logic [7:0]            window_enables_q;
    logic [7:0]            expansion_pin_assign_q;
    logic [7:0]            select_enable_q;
    logic [13:0]           stretch_q;
    logic [7:0]            misc_q;
    logic [MXP_NUM_CS-1:0] sel_meta_q;
    logic [MXP_NUM_CS-1:0] sel_sync_q;
    logic [MXP_NUM_EXT-1:0] exp_meta_q;
    logic [MXP_NUM_EXT-1:0] exp_sync_q;

    logic        wr_en;
    logic        rd_setup;
    logic [31:0] rd_d;
    logic        hit_d;

    logic data_window_on;
    logic program_window_on;
    logic extra_window_on;
    logic extra_window_location;
    logic single_chip;
    logic select_three_follows_extra;
    logic [MXP_NUM_EXT-1:0] ext_addr_pin_on;

    assign data_window_on             = window_enables_q[MXP_WIN_DATA_BIT];
    assign program_window_on          = window_enables_q[MXP_WIN_PROG_BIT];
    assign extra_window_on            = window_enables_q[MXP_WIN_XTRA_BIT];
    assign extra_window_location      = misc_q[MXP_MISC_LOC_BIT];
    assign single_chip                = misc_q[MXP_MISC_SGL_BIT];
    assign select_three_follows_extra = misc_q[MXP_MISC_FLW_BIT];
    assign ext_addr_pin_on = single_chip ? '0 : expansion_pin_assign_q[MXP_NUM_EXT-1:0];

    // ------------------------------------------------------------
    // apb slave: one setup cycle, one access cycle, never waits
    // ------------------------------------------------------------
    assign rd_setup = psel & ~penable & ~pready;
    assign wr_en    = psel & penable & pready & pwrite;

    always_comb begin
        rd_d  = '0;
        hit_d = 1'b1;
        unique case (paddr)
            MXP_OFF_SEL_DATA: begin
                // inputs read the pin, outputs the driven port value (chip-select level on claimed pins)
                rd_d[MXP_NUM_CS-1:0] = (select_port_oe & select_port_out) | (~select_port_oe & sel_sync_q);
            end
            MXP_OFF_EXP_DATA: begin
                rd_d[MXP_NUM_EXT-1:0] = (expansion_port_oe & expansion_port_out)
                                      | (~expansion_port_oe & exp_sync_q);
            end
            MXP_OFF_SEL_DIR:   rd_d[7:0]  = select_port_direction_q;
            MXP_OFF_EXP_DIR:   rd_d[7:0]  = expansion_port_direction_q;
            MXP_OFF_DATA_PAGE: rd_d[7:0]  = data_page_select_q;
            MXP_OFF_PROG_PAGE: rd_d[7:0]  = program_page_select_q;
            MXP_OFF_XTRA_PAGE: rd_d[7:0]  = extra_page_select_q;
            MXP_OFF_WIN_EN:    rd_d[7:0]  = window_enables_q;
            MXP_OFF_PIN_ASGN:  rd_d[7:0]  = expansion_pin_assign_q;
            MXP_OFF_SEL_EN:    rd_d[7:0]  = select_enable_q;
            MXP_OFF_STRETCH:   rd_d[13:0] = stretch_q;
            MXP_OFF_MISC:      rd_d[7:0]  = misc_q;
            default:           hit_d      = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= rd_setup;
            pslverr <= rd_setup & ~hit_d;
            prdata  <= rd_setup ? rd_d : '0;
        end
    end

    // ------------------------------------------------------------
    // register writes, all open at any time
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            select_port_data_q         <= MXP_RST_BYTE;
            expansion_port_data_q      <= MXP_RST_BYTE;
            select_port_direction_q    <= MXP_RST_BYTE;
            expansion_port_direction_q <= MXP_RST_BYTE;
            data_page_select_q         <= MXP_RST_BYTE;
            extra_page_select_q        <= MXP_RST_BYTE;
            window_enables_q           <= MXP_RST_BYTE;
            expansion_pin_assign_q     <= MXP_RST_BYTE;
            select_enable_q            <= MXP_RST_BYTE;
            stretch_q                  <= MXP_RST_STRETCH;
            misc_q                     <= MXP_RST_BYTE;
        end else if (wr_en) begin
            unique case (paddr)
                MXP_OFF_SEL_DATA:  select_port_data_q         <= pwdata[7:0];
                MXP_OFF_EXP_DATA:  expansion_port_data_q      <= pwdata[7:0];
                MXP_OFF_SEL_DIR:   select_port_direction_q    <= pwdata[7:0];
                MXP_OFF_EXP_DIR:   expansion_port_direction_q <= pwdata[7:0];
                MXP_OFF_DATA_PAGE: data_page_select_q         <= pwdata[7:0];
                MXP_OFF_XTRA_PAGE: extra_page_select_q        <= pwdata[7:0];
                MXP_OFF_WIN_EN:    window_enables_q           <= pwdata[7:0];
                MXP_OFF_PIN_ASGN:  expansion_pin_assign_q     <= pwdata[7:0];
                MXP_OFF_SEL_EN:    select_enable_q            <= pwdata[7:0];
                MXP_OFF_STRETCH:   stretch_q                  <= pwdata[13:0];
                MXP_OFF_MISC:      misc_q                     <= pwdata[7:0];
                default: begin
                end
            endcase
        end
    end

    // paged call/return outrank a software write in the same cycle,
    // so the instruction flow never sees a stale page
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            program_page_select_q <= MXP_RST_BYTE;
        end else if (page_call.load) begin
            program_page_select_q <= page_call.page;
        end else if (page_return.load) begin
            program_page_select_q <= page_return.page;
        end else if (wr_en && paddr == MXP_OFF_PROG_PAGE) begin
            program_page_select_q <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // pin input synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_meta_q <= '0;
            sel_sync_q <= '0;
            exp_meta_q <= '0;
            exp_sync_q <= '0;
        end else begin
            sel_meta_q <= select_port_in;
            sel_sync_q <= sel_meta_q;
            exp_meta_q <= expansion_port_in;
            exp_sync_q <= exp_meta_q;
        end
    end

    // ------------------------------------------------------------
    // address translation
    // ------------------------------------------------------------
    function automatic logic [21:0] mxp_translate(
        input logic [15:0] a,
        input logic        dwin,
        input logic        pwin,
        input logic        xwin,
        input logic [7:0]  dpg,
        input logic [7:0]  ppg,
        input logic [7:0]  xpg
    );
        logic [21:0] t;
        t = {6'h3F, a};
        if (dwin && a[15:12] == 4'h7) begin
            t[21:20] = 2'h3;
            t[19:12] = dpg;
        end else if (pwin && a[15:14] == 2'h2) begin
            t[21:14] = ppg;
        end else if (xwin) begin
            t[21:18] = 4'hF;
            t[17:10] = xpg;
        end
        t[9:0] = a[9:0];
        return t;
    endfunction

    logic [21:0] xlat;
    logic        in_extra;

    assign xlat = mxp_translate(cpu_access.addr, data_window_on, program_window_on, in_extra,
                                data_page_select_q, program_page_select_q, extra_page_select_q);
    assign in_extra = extra_window_on && cpu_access.addr[15:11] == 5'h00
                      && cpu_access.addr[10] == ~extra_window_location;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_addr <= {6'h3F, 16'h0000};
        end else if (cpu_access.valid) begin
            ext_addr <= xlat;
        end
    end

    // ------------------------------------------------------------
    // chip-select activity and stretch
    // ------------------------------------------------------------
    logic [MXP_NUM_CS-1:0] cs_act_d;
    logic [MXP_NUM_CS-1:0] cs_act_q;
    logic [1:0]            str_d;
    logic [1:0]            str_cnt_q;

    always_comb begin
        cs_act_d = cs_hit & select_enable_q[MXP_NUM_CS-1:0];
        if (select_three_follows_extra && in_extra) begin
            cs_act_d[MXP_CS_THREE] = select_enable_q[MXP_CS_THREE];
        end
        if (!cpu_access.valid) begin
            cs_act_d = '0;
        end
        str_d = 2'h0;
        for (int i = 0; i < MXP_NUM_CS; i++) begin
            if (cs_act_d[i] && stretch_q[2*i +: 2] > str_d) begin
                str_d = stretch_q[2*i +: 2];
            end
        end
    end

    // ------------------------------------------------------------
    // e-clock divider, stretched and plain
    // ------------------------------------------------------------
    logic [7:0] div_q;
    logic       e_tick;
    logic       eclk_q;
    logic       eclk_str_q;

    assign e_tick = (div_q == 8'(E_DIV - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= '0;
        end else begin
            div_q <= e_tick ? '0 : div_q + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_act_q  <= '0;
            str_cnt_q <= 2'h0;
        end else if (cpu_access.valid && str_cnt_q == 2'h0) begin
            cs_act_q  <= cs_act_d;
            str_cnt_q <= str_d;
        end else if (e_tick && eclk_str_q && eclk_q && str_cnt_q != 2'h0) begin
            // plain clock paces the count: one whole e-cycle per step, not a half
            str_cnt_q <= str_cnt_q - 2'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eclk_q     <= 1'b0;
            eclk_str_q <= 1'b0;
        end else if (e_tick) begin
            eclk_q <= ~eclk_q;
            if (!(eclk_str_q && str_cnt_q != 2'h0)) begin
                eclk_str_q <= ~eclk_str_q;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_stretch <= 1'b0;
            eclk_pin    <= 1'b0;
        end else begin
            bus_stretch <= str_cnt_q != 2'h0;
            if (misc_q[MXP_MISC_NCK_BIT]) begin
                eclk_pin <= 1'b0;
            end else if (misc_q[MXP_MISC_STR_BIT] || misc_q[MXP_MISC_VIS_BIT]) begin
                eclk_pin <= eclk_str_q;
            end else begin
                eclk_pin <= eclk_q;
            end
        end
    end

    // ------------------------------------------------------------
    // port pins
    // ------------------------------------------------------------
    logic [MXP_NUM_CS-1:0] cs_claim;

    assign cs_claim = single_chip ? '0 : select_enable_q[MXP_NUM_CS-1:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            select_port_out       <= '0;
            select_port_oe        <= '0;
            select_port_pullup    <= '0;
            expansion_port_out    <= '0;
            expansion_port_oe     <= '0;
            expansion_port_pullup <= '0;
        end else begin
            for (int i = 0; i < MXP_NUM_CS; i++) begin
                if (cs_claim[i]) begin
                    select_port_out[i] <= ~cs_act_q[i];
                    select_port_oe[i]  <= 1'b1;
                end else begin
                    select_port_out[i] <= select_port_data_q[i];
                    select_port_oe[i]  <= select_port_direction_q[i];
                end
                select_port_pullup[i] <= misc_q[MXP_MISC_PUP_BIT] & ~cs_claim[i]
                                         & ~select_port_direction_q[i];
            end
            for (int i = 0; i < MXP_NUM_EXT; i++) begin
                if (ext_addr_pin_on[i]) begin
                    expansion_port_out[i] <= ext_addr[16+i];
                    expansion_port_oe[i]  <= 1'b1;
                end else begin
                    expansion_port_out[i] <= expansion_port_data_q[i];
                    expansion_port_oe[i]  <= expansion_port_direction_q[i];
                end
                expansion_port_pullup[i] <= misc_q[MXP_MISC_PUP_BIT] & ~ext_addr_pin_on[i]
                                            & ~expansion_port_direction_q[i];
            end
        end
    end

endmodule

// >>> mxp_paging_sva.sv
// checker: port-level properties of the memory paging block
`timescale 1ns/1ps

module mxp_paging_sva
    import mxp_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    input wire mxp_access_t cpu_access,
    input wire logic [21:0] ext_addr
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence apb_setup;
        psel && !penable;
    endsequence
    sequence acc_in(logic [15:0] lo, logic [15:0] hi);
        cpu_access.valid && cpu_access.addr >= lo && cpu_access.addr <= hi;
    endsequence

    chk_setup_ready: assert property (apb_setup |=> pready)
        else $error("no ready after setup");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_idle_rdata: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    chk_low_pass: assert property (cpu_access.valid |=> ext_addr[9:0] == $past(cpu_access.addr[9:0]))
        else $error("low address bits changed");
    chk_top_unpaged: assert property (acc_in(16'hC000, 16'hFFFF) |=>
        ext_addr[21:10] == {6'h3F, $past(cpu_access.addr[15:10])}) else $error("top space translated");
    chk_mid_unpaged: assert property (acc_in(16'h0800, 16'h6FFF) |=>
        ext_addr[21:10] == {6'h3F, $past(cpu_access.addr[15:10])}) else $error("middle space translated");
    chk_data_top: assert property (acc_in(16'h7000, 16'h7FFF) |=> ext_addr[21:20] == 2'h3)
        else $error("data window top bits low");
    chk_extra_top: assert property (acc_in(16'h0000, 16'h07FF) |=> ext_addr[21:18] == 4'hF)
        else $error("extra window top bits low");
    chk_addr_hold: assert property (!cpu_access.valid |=> $stable(ext_addr))
        else $error("address moved without access");
endmodule

bind mxp_paging mxp_paging_sva mxp_paging_sva_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .cpu_access(cpu_access), .ext_addr(ext_addr)
);

// >>> mxp_ext_pins.sv
// model: external devices and pull-ups on the select and expansion port pins
`timescale 1ns/1ps

module mxp_ext_pins (
    input  wire logic [12:0] pin_out,
    input  wire logic [12:0] pin_oe,
    input  wire logic [12:0] pin_pu,
    input  wire logic [12:0] dev_en,
    input  wire logic [12:0] dev_val,
    output logic      [12:0] pin_lvl
);
    // a released pin with no device enabled shows the inverse of its last drive unless pulled up
    assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & dev_en & dev_val)
                   | (~pin_oe & ~dev_en & (pin_pu | ~pin_out));
endmodule

// >>> tb.sv
// testbench: registers, paging, port pins, stretch and clock pin
`timescale 1ns/1ps

module tb;
    import mxp_pkg::*;
    localparam int EDIV = 2;
    localparam int E2 = 2 * EDIV;
    localparam logic [7:0]  OFFS [10] = '{MXP_OFF_SEL_DIR, MXP_OFF_EXP_DIR, MXP_OFF_PROG_PAGE, MXP_OFF_XTRA_PAGE,
        MXP_OFF_WIN_EN, MXP_OFF_PIN_ASGN, MXP_OFF_SEL_EN, MXP_OFF_STRETCH, MXP_OFF_MISC, MXP_OFF_DATA_PAGE};
    localparam logic [15:0] BASE [6] = '{16'h0000, 16'h0400, 16'h7000, 16'h8000, 16'h6C00, 16'hC000};
    localparam logic [15:0] SPAN [6] = '{16'h03FF, 16'h03FF, 16'h0FFF, 16'h3FFF, 16'h03FF, 16'h3FFF};
    logic           pclk, presetn, psel, penable, pwrite, pready, pslverr, bus_stretch, eclk_pin, av_q;
    logic [7:0]     paddr;
    logic [31:0]    pwdata, prdata;
    mxp_access_t    cpu_access;
    mxp_page_load_t page_call, page_return;
    logic [6:0]     cs_hit, sel_out, sel_oe, sel_pu;
    logic [5:0]     exp_out, exp_oe, exp_pu;
    logic [21:0]    ext_addr;
    logic [12:0]    dev_en, dev_val, pin_lvl;
    logic [32:0]    rd_q [$];
    logic [21:0]    ad_q [$];
    logic [32:0]    e_m;
    int             mismatches, total_checks, cyc;

    mxp_paging #(.E_DIV(EDIV)) mxp_paging_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cpu_access(cpu_access), .cs_hit(cs_hit), .page_call(page_call), .page_return(page_return),
        .ext_addr(ext_addr), .bus_stretch(bus_stretch), .eclk_pin(eclk_pin), .select_port_in(pin_lvl[6:0]),
        .select_port_out(sel_out), .select_port_oe(sel_oe), .select_port_pullup(sel_pu),
        .expansion_port_in(pin_lvl[12:7]), .expansion_port_out(exp_out), .expansion_port_oe(exp_oe),
        .expansion_port_pullup(exp_pu));
    mxp_ext_pins mxp_ext_pins_inst (.pin_out({exp_out, sel_out}), .pin_oe({exp_oe, sel_oe}),
        .pin_pu({exp_pu, sel_pu}), .dev_en(dev_en), .dev_val(dev_val), .pin_lvl(pin_lvl));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // apb master; expectation queued before the request
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
        rd_q.push_back(e);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask

    task automatic acc(input logic [15:0] a, input logic [21:0] e);
        ad_q.push_back(e);
        cpu_access <= '{1'b1, a};
        @(posedge pclk);
        cpu_access <= '{1'b0, 16'h0};
        @(posedge pclk);
    endtask

    function automatic logic [21:0] xlat(input logic [15:0] a, input logic [7:0] we, input logic loc,
                                         input logic [7:0] dp, input logic [7:0] pp, input logic [7:0] xp);
        if (we[MXP_WIN_DATA_BIT] && a[15:12] == 4'h7) return {2'h3, dp, a[11:0]};
        if (we[MXP_WIN_PROG_BIT] && a[15:14] == 2'h2) return {pp, a[13:0]};
        if (we[MXP_WIN_XTRA_BIT] && a[15:10] == {5'h0, ~loc}) return {4'hF, xp, a[9:0]};
        return {6'h3F, a};
    endfunction

    always @(posedge pclk) begin
        if (pready === 1'b1 && psel === 1'b1) begin
            e_m = rd_q.pop_front();
            if (pwrite) chk("apb error", 33'(e_m[32]), 33'(pslverr));
            else chk("apb read", e_m, {pslverr, prdata});
        end
        if (av_q) chk("ext address", 33'(ad_q.pop_front()), 33'(ext_addr));
        av_q = cpu_access.valid;
        cyc++;
        if (cyc > 20000) begin
            mismatches++;
            report_and_stop();
        end
    end

    initial begin
        logic [7:0]  dp, pp, xp, we;
        logic [15:0] a;
        logic [31:0] d;
        int          cnt, lo;
        {psel, penable, pwrite, paddr, pwdata, cs_hit, dev_en, dev_val, presetn} = '0;
        cpu_access = '0;
        page_call = '0;
        page_return = '0;
        {mismatches, total_checks, cyc, av_q} = '0;
        d = $urandom(35499);
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (OFFS[i]) apb(1'b0, OFFS[i], 32'h0, 33'h0);
        apb(1'b0, 8'h30, 32'h0, {1'b1, 32'h0});
        apb(1'b1, 8'h30, 32'hFF, {1'b1, 32'h0});
        foreach (OFFS[i]) begin
            d = $urandom;
            wr(OFFS[i], d);
            apb(1'b0, OFFS[i], 32'h0, {1'b0, d & (OFFS[i] == MXP_OFF_STRETCH ? 32'h3FFF : 32'hFF)});
        end
        $display("test registers done");
        for (int w = 0; w < 16; w++) begin
            we = {w[2:0], 5'h0};
            {dp, pp, xp} = 24'($urandom);
            wr(MXP_OFF_DATA_PAGE, dp);
            wr(MXP_OFF_PROG_PAGE, pp);
            wr(MXP_OFF_XTRA_PAGE, xp);
            wr(MXP_OFF_WIN_EN, we);
            wr(MXP_OFF_MISC, {31'h0, w[3]});
            foreach (BASE[k]) begin
                a = BASE[k] | (16'($urandom) & SPAN[k]);
                acc(a, xlat(a, we, w[3], dp, pp, xp));
            end
        end
        $display("test paging done");
        wr(MXP_OFF_WIN_EN, 32'h40);
        for (int k = 0; k < 2; k++) begin
            pp = 8'($urandom);
            if (k == 0) page_call <= '{1'b1, pp};
            else page_return <= '{1'b1, pp};
            @(posedge pclk);
            page_call <= '0;
            page_return <= '0;
            acc(16'h8ABC, {pp, 14'h0ABC});
            apb(1'b0, MXP_OFF_PROG_PAGE, 32'h0, 33'(pp));
        end
        $display("test page call done");
        wr(MXP_OFF_WIN_EN, 32'h0);
        wr(MXP_OFF_EXP_DIR, 32'h15);
        wr(MXP_OFF_EXP_DATA, 32'h3F);
        wr(MXP_OFF_PIN_ASGN, 32'h21);
        wr(MXP_OFF_SEL_EN, 32'h01);
        wr(MXP_OFF_SEL_DIR, 32'h0);
        wr(MXP_OFF_MISC, 32'h10);
        @(posedge pclk);
        chk("exp oe", 33'h35, 33'(exp_oe));
        chk("exp pullup", 33'h0A, 33'(exp_pu));
        chk("exp out", 33'h14, 33'(exp_out & 6'h14));
        chk("sel oe", 33'h01, 33'(sel_oe));
        chk("sel pullup", 33'h7E, 33'(sel_pu));
        wr(MXP_OFF_MISC, 32'h30);
        @(posedge pclk);
        chk("exp oe single chip", 33'h15, 33'(exp_oe));
        wr(MXP_OFF_PIN_ASGN, 32'h0);
        d = $urandom;
        dev_en <= 13'h1FFF;
        dev_val <= d[12:0];
        repeat (4) @(posedge pclk);
        apb(1'b0, MXP_OFF_EXP_DATA, 32'h0, 33'((d[12:7] & 6'h2A) | 6'h15));
        $display("test pins done");
        wr(MXP_OFF_MISC, 32'h0);
        cs_hit <= 7'h01;
        for (int n = 0; n < 4; n++) begin
            wr(MXP_OFF_STRETCH, n);
            acc(16'h9000, {6'h3F, 16'h9000});
            {cnt, lo} = '0;
            repeat (40) begin
                @(posedge pclk);
                cnt += int'(bus_stretch === 1'b1);
                lo |= int'(sel_out[0] === 1'b0);
            end
            chk("select low", 33'h1, 33'(lo));
            chk("stretch", 33'h1, 33'((cnt <= E2 * (n + 1)) && (cnt + E2 >= E2 * n) && ((n == 0) == (cnt == 0))));
        end
        cs_hit <= 7'h00;
        wr(MXP_OFF_SEL_EN, 32'h40);
        wr(MXP_OFF_WIN_EN, 32'h20);
        wr(MXP_OFF_MISC, 32'h41);
        acc(16'h0123, {4'hF, xp, 10'h123});
        @(posedge pclk);
        chk("select three", 33'h0, 33'(sel_out[6]));
        $display("test stretch done");
        for (int k = 0; k < 2; k++) begin
            wr(MXP_OFF_MISC, k ? 32'h0 : 32'h08);
            cnt = 0;
            repeat (20) begin
                @(posedge pclk);
                cnt += int'(eclk_pin === 1'b1);
            end
            chk("clock pin active", 33'(k), 33'(cnt > 3));
        end
        $display("test clock pin done");
        report_and_stop();
    end
endmodule
